/* rtl/lmf_device.sv */
// device end: operating mode state machine with fault line and register reloads
`include "lmf_consts.svh"
module lmf_device
  import lmf_pkg::*;
(
  input  wire logic                  clk,             // 25 MHz clock
  input  wire logic                  rst,             // synchronous reset
  lmf_link_if.device                 link,            // host side
  input  wire logic                  supply_ok,       // supply above threshold
  input  wire logic                  regulator_ok,    // regulator above threshold
  input  wire logic                  failsafe_select_pin, // fail-safe set select
  input  wire logic                  ref_pin_high,    // reference pin raised
  input  wire logic                  overtemp,        // overtemperature
  input  wire logic [`LMF_CH_N-1:0]  channel_fault,   // per-channel output fault
  input  wire logic                  critical_fault,  // critical fault in normal
  input  wire logic                  noncrit_fault,   // non-critical fault in normal
  input  wire logic [3:0]            init_delay_setting,
  input  wire logic [3:0]            watchdog_period_setting,
  input  wire logic                  all_fail_select,
  input  wire logic [`LMF_CH_N-1:0]  failsafe0_channel_mask,
  input  wire logic [`LMF_CH_N-1:0]  failsafe1_channel_mask,
  input  wire logic [`LMF_CH_N-1:0]  stored_channel_diag_enable,
  input  wire logic [`LMF_CH_N-1:0]  host_channel_enable,  // host written enables
  input  wire logic                  host_enable_write,    // strobe for the above
  output logic      [`LMF_CH_N-1:0]  channel_on,      // channel drive
  output logic      [`LMF_CH_N-1:0]  channel_diag_enable,
  output logic                       low_current,     // low current fault mode
  output logic                       mirror_reload,   // pulse: mirrored regs reload
  output logic                       plain_clear      // pulse: unmirrored regs clear
);
  localparam int PULSE_CYC = `LMF_ERR_PULSE_CYC;

  // all state of the module
  typedef struct packed {
    lmf_mode_t                mode;
    logic [`LMF_CNT_W-1:0]    cnt;       // init delay or watchdog count
    logic [`LMF_CNT_W-1:0]    pulse;     // fault line pulse remainder
    logic                     hold;      // constant pull
    logic                     armed_n;   // report used, wait for flag clear
    logic                     err_flag;
    logic                     pin_flag;
    logic                     lock;
    logic [`LMF_CH_N-1:0]     en;
    logic [`LMF_CH_N-1:0]     diag;
    logic [`LMF_CH_N-1:0]     failed;
    logic                     lowc;
    logic                     reload;
    logic                     clear;
    logic                     link_en;   // flopped link enable
    logic                     oe;        // flopped fault line pull
  } lmf_dev_state_t;

  lmf_dev_state_t s_reg;
  lmf_dev_state_t s_next;
  logic [`LMF_CNT_W-1:0] init_lim;  // init delay in cycles
  logic [`LMF_CNT_W-1:0] wd_lim;    // watchdog period in cycles
  logic                  fs_entry;  // entering fail-safe this cycle
  logic                  any_fail;  // diagnosed channel fault

  // delay lengths; watchdog settings past the last option saturate
  always_comb begin
    init_lim = `LMF_CNT_W'((32'(init_delay_setting) + 1) * `LMF_INIT_UNIT_CYC);
    if (watchdog_period_setting >= 4'(`LMF_WD_OPTIONS)) begin
      wd_lim = `LMF_CNT_W'(`LMF_WD_OPTIONS * `LMF_WD_UNIT_CYC);
    end else begin
      wd_lim = `LMF_CNT_W'((32'(watchdog_period_setting) + 1) * `LMF_WD_UNIT_CYC);
    end
  end

  // next state
  always_comb begin
    s_next        = s_reg;
    s_next.reload = 1'b0;
    s_next.clear  = 1'b0;
    fs_entry      = 1'b0;
    any_fail      = |(channel_fault & s_reg.diag & s_reg.en);
    s_next.pin_flag = failsafe_select_pin;
    if (s_reg.pulse != '0) begin
      s_next.pulse = s_reg.pulse - 1'b1;
    end
    unique case (s_reg.mode)
      LMF_POR: begin
        if (supply_ok && regulator_ok) begin
          s_next.mode   = LMF_INIT;
          s_next.cnt    = '0;
          s_next.en     = '0;
          s_next.diag   = stored_channel_diag_enable;
          s_next.reload = 1'b1;
          s_next.clear  = 1'b1;
        end
      end
      LMF_INIT: begin
        s_next.cnt = s_reg.cnt + 1'b1;
        if (link.cmd.reset_flag_clear || s_reg.cnt >= init_lim) begin
          s_next.mode = LMF_NORMAL;
          s_next.cnt  = '0;
          s_next.err_flag = 1'b0;
        end
      end
      LMF_NORMAL: begin
        s_next.cnt = link.cmd.instruction ? '0 : s_reg.cnt + 1'b1;
        if (host_enable_write && !s_reg.lock) begin
          s_next.en = host_channel_enable;
        end
        if (link.cmd.reset_flag_clear) begin
          s_next.err_flag = 1'b0;
          s_next.armed_n  = 1'b0;
          s_next.hold     = 1'b0;
        end
        // report only; an event in the clear cycle wins so it is never lost
        if ((critical_fault || noncrit_fault || link.cmd.force_error) &&
            (!s_reg.armed_n || link.cmd.reset_flag_clear)) begin
          s_next.err_flag = 1'b1;
          s_next.armed_n  = 1'b1;
          s_next.hold     = critical_fault;
          if (!critical_fault) begin
            s_next.pulse = `LMF_CNT_W'(PULSE_CYC);
          end
        end
        if (link.cmd.register_reset) begin
          s_next.reload = 1'b1;
          s_next.clear  = 1'b1;
        end else if (link.cmd.eeprom_reload) begin
          s_next.reload = 1'b1;
        end
        if (ref_pin_high || link.cmd.prog_sequence) begin
          s_next.mode = LMF_PROG;
        end else if (link.cmd.force_failsafe || s_reg.cnt >= wd_lim) begin
          fs_entry = 1'b1;
        end
      end
      LMF_FS: begin
        s_next.en = failsafe_select_pin ? failsafe1_channel_mask : failsafe0_channel_mask;
        if (link.cmd.lock_write) begin
          s_next.lock = link.cmd.lock_value;
        end
        if (any_fail || !link.fault_in) begin
          s_next.mode     = LMF_OUTPUT_FAILURE_STATE;
          s_next.err_flag = 1'b1;
          s_next.failed   = channel_fault & s_reg.diag;
        end else if (link.cmd.failsafe_exit && !s_reg.lock) begin
          s_next.mode     = LMF_NORMAL;
          s_next.cnt      = '0;
          s_next.err_flag = 1'b0;
          s_next.armed_n  = 1'b0;
          s_next.hold     = 1'b0;
        end
      end
      LMF_OUTPUT_FAILURE_STATE: begin
        s_next.failed = s_reg.failed | (channel_fault & s_reg.diag);
        // all-fail on low line when all_fail_select is set, else failed only
        if (all_fail_select && !link.fault_in) begin
          s_next.en   = '0;
          s_next.diag = '0;
          s_next.lowc = 1'b1;
        end else begin
          s_next.en = (failsafe_select_pin ? failsafe1_channel_mask
                                           : failsafe0_channel_mask) & ~s_next.failed;
        end
      end
      LMF_PROG: begin
        // diagnostics ignored here; leave on fail-safe exit once the pin has dropped
        if (!ref_pin_high && link.cmd.failsafe_exit) begin
          s_next.mode = LMF_NORMAL;
          s_next.cnt  = '0;
        end
      end
    endcase
    if (fs_entry) begin
      s_next.mode   = LMF_FS;
      s_next.en     = failsafe_select_pin ? failsafe1_channel_mask : failsafe0_channel_mask;
      s_next.diag   = stored_channel_diag_enable;
      s_next.lock   = 1'b1;
      s_next.failed = '0;
      s_next.hold   = 1'b0;
      s_next.pulse  = '0;
      s_next.reload = 1'b1;
      s_next.clear  = 1'b1;
    end
    // rail dip wins over all; overtemp kept in every state
    if (!(supply_ok && regulator_ok)) begin
      s_next = '0;
      s_next.mode = LMF_POR;
    end else if (overtemp) begin
      s_next.en = '0;
    end
    // link enable worked out ahead so the pin comes from a flop
    s_next.link_en = (s_next.mode != LMF_POR) && !s_next.lowc;
    // line pull, also flopped to keep the open-drain pin glitch free
    s_next.oe      = s_next.hold || (s_next.pulse != '0) ||
                     (s_next.mode == LMF_OUTPUT_FAILURE_STATE && s_next.failed != '0);
  end

  // register the state; reset clears everything except mode, which goes to LMF_POR
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg      <= '0;
      s_reg.mode <= LMF_POR;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from state flops, except fault_dev_o, tied low
  assign channel_on          = s_reg.en;
  assign channel_diag_enable = s_reg.diag;
  assign low_current         = s_reg.lowc;
  assign mirror_reload       = s_reg.reload;
  assign plain_clear         = s_reg.clear;
  assign link.mode           = s_reg.mode;
  assign link.err_flag       = s_reg.err_flag;
  assign link.pin_level_flag = s_reg.pin_flag;
  assign link.lock_flag      = s_reg.lock;
  // link silent in reset and low current mode
  assign link.link_enabled   = s_reg.link_en;
  assign link.fault_dev_o    = 1'b0;
  assign link.fault_dev_oe   = s_reg.oe;
endmodule : lmf_device

/* rtl/lmf_consts.svh */
// constants for the led driver mode state machine
`ifndef LMF_CONSTS_SVH
`define LMF_CONSTS_SVH
`define LMF_CLK_HZ          25000000
`define LMF_CH_N            12
`define LMF_ERR_PULSE_US    50
`define LMF_ERR_PULSE_CYC   ((`LMF_ERR_PULSE_US * `LMF_CLK_HZ) / 1000000)
`define LMF_INIT_UNIT_CYC   250
`define LMF_WD_UNIT_CYC     250
`define LMF_WD_OPTIONS      13
`define LMF_MIRROR_WORDS    36
`define LMF_CNT_W           20
`endif

/* rtl/lmf_pkg.sv */
// types for the led driver mode state machine
package lmf_pkg;
  // one-hot operating modes
  typedef enum logic [5:0] {
    LMF_POR     = 6'h01,
    LMF_INIT    = 6'h02,
    LMF_NORMAL  = 6'h04,
    LMF_FS      = 6'h08,
    LMF_PROG    = 6'h10,
    LMF_OUTPUT_FAILURE_STATE = 6'h20
  } lmf_mode_t;
  // host command strobes, one cycle each
  typedef struct packed {
    logic reset_flag_clear;
    logic force_failsafe;
    logic failsafe_exit;
    logic lock_write;
    logic lock_value;
    logic force_error;
    logic register_reset;
    logic eeprom_reload;
    logic prog_sequence;
    logic instruction;
  } lmf_cmd_t;
endpackage : lmf_pkg

/* rtl/lmf_link_if.sv */
// link between host controller and led driver mode logic
interface lmf_link_if;
  import lmf_pkg::*;
  lmf_cmd_t    cmd;             // command strobes from host
  logic        link_enabled;    // device answers the serial bus
  lmf_mode_t   mode;            // device mode seen by host readback
  logic        err_flag;        // error flag readback
  logic        pin_level_flag;  // failsafe select pin level readback
  logic        lock_flag;       // write lock readback
  logic        fault_dev_o;     // device drives fault line out (low)
  logic        fault_dev_oe;    // device pulls fault line
  logic        fault_in;        // resolved fault line level (testbench)
  modport device (input cmd, fault_in, output link_enabled, mode, err_flag,
                  pin_level_flag, lock_flag, fault_dev_o, fault_dev_oe);
  modport host (output cmd, input link_enabled, mode, err_flag, pin_level_flag,
                lock_flag, fault_in);
endinterface : lmf_link_if

/* rtl/lmf_host.sv */
// host end: issues command strobes to the led driver mode logic
module lmf_host
  import lmf_pkg::*;
(
  input  wire logic  clk,        // 25 MHz clock
  input  wire logic  rst,        // synchronous reset
  lmf_link_if.host   link,       // device side
  input  wire logic  req_valid,  // user command request
  input  wire logic  [9:0] req_cmd, // user strobe bits, lmf_cmd_t layout
  output logic       req_ready,  // command accepted this cycle
  output logic       dev_fault,  // fault line seen low
  output lmf_mode_t  dev_mode    // device mode
);
  // all state of the module
  typedef struct packed {
    lmf_cmd_t  cmd;
    logic      ready;
    logic      fault;
    lmf_mode_t mode;
  } lmf_host_state_t;

  lmf_host_state_t s_reg;
  lmf_host_state_t s_next;

  // pass commands only while the device answers
  always_comb begin
    s_next       = s_reg;
    s_next.cmd   = '0;
    s_next.ready = 1'b0;
    s_next.fault = !link.fault_in;
    s_next.mode  = link.mode;
    if (req_valid && link.link_enabled && !s_reg.ready) begin
      s_next.cmd   = lmf_cmd_t'(req_cmd);
      s_next.ready = 1'b1;
      // exit is withheld while the lock flag stands, unless the same request writes the lock with lock_value 0
      if (link.lock_flag && !(req_cmd[6] && !req_cmd[5])) begin
        s_next.cmd.failsafe_exit = 1'b0;
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg      <= '0;
      s_reg.mode <= LMF_POR;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.cmd  = s_reg.cmd;
  assign req_ready = s_reg.ready;
  assign dev_fault = s_reg.fault;
  assign dev_mode  = s_reg.mode;
endmodule : lmf_host

/* tb/lmf_link_props.sv */
// concurrent checks on the link between host and device ends
module lmf_link_props
  import lmf_pkg::*;
(
  input wire logic      clk,
  input wire logic      rst,
  input wire lmf_cmd_t  cmd,
  input wire logic      link_enabled,
  input wire lmf_mode_t mode,
  input wire logic      err_flag,
  input wire logic      lock_flag,
  input wire logic      fault_dev_o,
  input wire logic      fault_dev_oe
);
  logic [11:0] oe_cnt_reg; // cycles the line has been pulled so far
  logic        forced_reg; // current pull was launched by force error
  // helper: the count survives the falling edge so the pulse length is visible there
  always_ff @(posedge clk) begin
    if (rst || !fault_dev_oe) oe_cnt_reg <= 12'h000;
    else oe_cnt_reg <= oe_cnt_reg + 12'h001;
    if (rst) forced_reg <= 1'b0;
    else if (mode == LMF_NORMAL && cmd.force_error && !err_flag) forced_reg <= 1'b1;
    else if (!fault_dev_oe && oe_cnt_reg != 12'h000) forced_reg <= 1'b0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  por_link_quiet_a: assert property (mode == LMF_POR |-> !link_enabled)
    else $error("link answers in reset mode");
  init_skip_a: assert property (mode == LMF_INIT && cmd.reset_flag_clear |=>
    mode == LMF_NORMAL) else $error("flag clear did not end init");
  force_fs_a: assert property (mode == LMF_NORMAL && cmd.force_failsafe |=>
    mode == LMF_FS) else $error("forced fail-safe not entered");
  fs_lock_a: assert property (mode == LMF_FS && $past(mode) == LMF_NORMAL |->
    lock_flag) else $error("lock not set on fail-safe entry");
  locked_exit_a: assert property (mode == LMF_FS && lock_flag && cmd.failsafe_exit
    |=> mode == LMF_FS) else $error("exit taken while locked");
  unlocked_exit_a: assert property (mode == LMF_FS && !lock_flag && cmd.failsafe_exit
    |=> mode == LMF_NORMAL && !err_flag) else $error("unlocked exit failed");
  force_err_a: assert property (mode == LMF_NORMAL && cmd.force_error && !err_flag
    |=> err_flag ##[0:4] fault_dev_oe) else $error("force error gave no pull");
  err_pulse_a: assert property (forced_reg && !fault_dev_oe && oe_cnt_reg != 12'h000
    |-> oe_cnt_reg == 12'h4E2) else $error("error pulse length wrong");
  line_low_only_a: assert property (fault_dev_o == 1'b0)
    else $error("fault line driven high");
endmodule // lmf_link_props

/* tb/led_driver_mode_fsm_tb.sv */
// self-checking bench joining host and device ends
module led_driver_mode_fsm_tb
  import lmf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst = 1'b1, supply_ok = 1'b0, regulator_ok = 1'b0;
  logic        fs_pin = 1'b0, ref_pin_high = 1'b0, all_fail_select = 1'b0;
  logic        critical_fault = 1'b0, ext_low = 1'b0, req_valid = 1'b0;
  logic        noncrit = 1'b0, overtemp = 1'b0;
  logic [11:0] chf = 12'h000, f;
  logic [3:0]  init_set = 4'h0, wd_set = 4'hF;
  logic [11:0] mask0 = 12'h000, mask1 = 12'h000, diag = 12'h000;
  logic [9:0]  req_cmd = 10'h000;
  logic        req_ready, dev_fault, low_current, mirror_reload, plain_clear;
  logic [11:0] channel_on, channel_diag_enable;
  lmf_mode_t   dev_mode;
  int          err_total = 0, samples_checked = 0, reloads = 0, clears = 0;
  int          oe_run = 0, last_run = 0, n, s;
  lmf_link_if link ();
  // ext_low stands in for a second device sharing the open-drain line
  assign link.fault_in = !(link.fault_dev_oe || ext_low);
  always #20 clk = ~clk;
  // pulse counters and pull length; a pulse seen twice would count twice
  always @(posedge clk) begin
    if (mirror_reload === 1'b1) reloads++;
    if (plain_clear === 1'b1) clears++;
    if (link.fault_dev_oe === 1'b1) oe_run++;
    else if (oe_run != 0) begin
      last_run = oe_run;
      oe_run = 0;
    end
  end
  lmf_device lmf_device_i (.clk(clk), .rst(rst), .link(link), .supply_ok(supply_ok),
    .regulator_ok(regulator_ok), .failsafe_select_pin(fs_pin), .ref_pin_high(ref_pin_high),
    .overtemp(overtemp), .channel_fault(chf), .critical_fault(critical_fault),
    .noncrit_fault(noncrit), .init_delay_setting(init_set), .watchdog_period_setting(wd_set),
    .all_fail_select(all_fail_select), .failsafe0_channel_mask(mask0),
    .failsafe1_channel_mask(mask1), .stored_channel_diag_enable(diag),
    .host_channel_enable(12'h000), .host_enable_write(1'b0), .channel_on(channel_on),
    .channel_diag_enable(channel_diag_enable), .low_current(low_current),
    .mirror_reload(mirror_reload), .plain_clear(plain_clear));
  lmf_host lmf_host_i (.clk(clk), .rst(rst), .link(link), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_ready(req_ready), .dev_fault(dev_fault), .dev_mode(dev_mode));
  lmf_link_props lmf_link_props_i (.clk(clk), .rst(rst), .cmd(link.cmd),
    .link_enabled(link.link_enabled), .mode(link.mode), .err_flag(link.err_flag),
    .lock_flag(link.lock_flag), .fault_dev_o(link.fault_dev_o),
    .fault_dev_oe(link.fault_dev_oe));
  function automatic logic [15:0] md(lmf_mode_t m);
    return {10'h000, m};
  endfunction
  function automatic logic [11:0] fs_mask(logic p);
    return p ? mask1 : mask0;
  endfunction
  // lowest set bit, used to place one channel fault
  function automatic logic [11:0] low_bit(logic [11:0] v);
    return v & (~v + 12'h001);
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(int c);
    repeat (c) @(posedge clk);
  endtask
  // one request, held until ready is sampled, then the spacing the host needs
  task automatic send(logic [9:0] c);
    int w;
    w = 0;
    req_valid <= 1'b1;
    req_cmd   <= c;
    do begin
      @(posedge clk);
      w++;
    end while (req_ready !== 1'b1 && w < 50);
    chk("ready", 16'h0001, {15'h0, req_ready});
    req_valid <= 1'b0;
    tick(3);
  endtask
  task automatic test_done();
    if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    tick(40000);
    err_total++;
    test_done();
  end
  initial begin
    void'($urandom(32'h6E3A));
    init_set <= 4'($urandom_range(3));
    // corner: channel 0 enabled and diagnosed in both sets, so a fault always lands
    mask0 <= 12'($urandom) | 12'h001;
    mask1 <= 12'($urandom) | 12'h001;
    diag <= 12'($urandom) | 12'h001;
    tick(12);
    rst <= 1'b0;
    tick(5);
    chk("mode", md(LMF_POR), md(dev_mode));
    chk("link", 16'h0000, {15'h0, link.link_enabled});
    n = reloads;
    supply_ok <= 1'b1;
    regulator_ok <= 1'b1;
    tick(4);
    chk("mode", md(LMF_INIT), md(link.mode));
    chk("reloads", 16'(n + 1), 16'(reloads));
    chk("enables", 16'h0000, {4'h0, channel_on});
    tick((int'(init_set) + 1) * 250 - 14);
    chk("mode", md(LMF_INIT), md(link.mode));
    tick(24);
    chk("mode", md(LMF_NORMAL), md(link.mode));
    supply_ok <= 1'b0;
    tick(3);
    chk("mode", md(LMF_POR), md(link.mode));
    supply_ok <= 1'b1;
    tick(4);
    send(10'h200);
    chk("mode", md(LMF_NORMAL), md(link.mode));
    n = reloads;
    s = clears;
    send(10'h005);
    chk("reloads", 16'(n + 1), 16'(reloads));
    chk("clears", 16'(s), 16'(clears));
    send(10'h009);
    chk("clears", 16'(s + 1), 16'(clears));
    send(10'h011);
    chk("err", 16'h0001, {15'h0, link.err_flag});
    tick(1300);
    chk("pulse", 16'h04E2, 16'(last_run));
    send(10'h011);
    tick(10);
    chk("pull", 16'h0000, {15'h0, link.fault_dev_oe});
    send(10'h201);
    critical_fault <= 1'b1;
    tick(1500);
    chk("pull", 16'h0001, {15'h0, link.fault_dev_oe});
    chk("dev fault", 16'h0001, {15'h0, dev_fault});
    critical_fault <= 1'b0;
    send(10'h201);
    tick(5);
    chk("pull", 16'h0000, {15'h0, link.fault_dev_oe});
    noncrit <= 1'b1;
    tick(1300);
    chk("err", 16'h0001, {15'h0, link.err_flag});
    chk("pulse", 16'h04E2, 16'(last_run));
    chk("pull", 16'h0000, {15'h0, link.fault_dev_oe});
    noncrit <= 1'b0;
    send(10'h201);
    wd_set <= 4'($urandom_range(3));
    fs_pin <= 1'($urandom_range(1));
    repeat (4) begin
      tick(200);
      send(10'h001);
    end
    chk("mode", md(LMF_NORMAL), md(link.mode));
    n = reloads;
    s = clears;
    tick((int'(wd_set) + 1) * 250 - 30);
    chk("mode", md(LMF_NORMAL), md(link.mode));
    tick(40);
    chk("mode", md(LMF_FS), md(link.mode));
    chk("lock", 16'h0001, {15'h0, link.lock_flag});
    chk("enables", {4'h0, fs_mask(fs_pin)}, {4'h0, channel_on});
    chk("diag", {4'h0, diag}, {4'h0, channel_diag_enable});
    chk("reloads", 16'(n + 1), 16'(reloads));
    chk("clears", 16'(s + 1), 16'(clears));
    fs_pin <= ~fs_pin;
    tick(4);
    chk("pin flag", {15'h0, fs_pin}, {15'h0, link.pin_level_flag});
    chk("mode", md(LMF_FS), md(link.mode));
    chk("lock", 16'h0001, {15'h0, link.lock_flag});
    chk("enables", {4'h0, fs_mask(fs_pin)}, {4'h0, channel_on});
    send(10'h080);
    chk("mode", md(LMF_FS), md(link.mode));
    send(10'h0C0);
    chk("mode", md(LMF_FS), md(link.mode));
    chk("lock", 16'h0000, {15'h0, link.lock_flag});
    send(10'h080);
    chk("mode", md(LMF_NORMAL), md(link.mode));
    overtemp <= 1'b1;
    tick(3);
    chk("enables", 16'h0000, {4'h0, channel_on});
    overtemp <= 1'b0;
    send(10'h101);
    chk("mode", md(LMF_FS), md(link.mode));
    all_fail_select <= 1'b1;
    ext_low <= 1'b1;
    tick(6);
    chk("mode", md(LMF_OUTPUT_FAILURE_STATE), md(link.mode));
    chk("enables", 16'h0000, {4'h0, channel_on});
    chk("diag", 16'h0000, {4'h0, channel_diag_enable});
    chk("low current", 16'h0001, {15'h0, low_current});
    chk("link", 16'h0000, {15'h0, link.link_enabled});
    ext_low <= 1'b0;
    supply_ok <= 1'b0;
    tick(3);
    supply_ok <= 1'b1;
    tick(4);
    send(10'h201);
    all_fail_select <= 1'b0;
    send(10'h101);
    chk("mode", md(LMF_FS), md(link.mode));
    f = low_bit(diag & fs_mask(fs_pin));
    chf <= f;
    tick(4);
    chk("mode", md(LMF_OUTPUT_FAILURE_STATE), md(link.mode));
    chk("enables", {4'h0, fs_mask(fs_pin) & ~f}, {4'h0, channel_on});
    chk("pull", 16'h0001, {15'h0, link.fault_dev_oe});
    chk("low current", 16'h0000, {15'h0, low_current});
    chf <= 12'h000;
    supply_ok <= 1'b0;
    tick(3);
    supply_ok <= 1'b1;
    tick(4);
    send(10'h201);
    ref_pin_high <= 1'b1;
    tick(4);
    chk("mode", md(LMF_PROG), md(link.mode));
    test_done();
  end
endmodule // led_driver_mode_fsm_tb
